// >>> include/fwp_pkg.sv
// Shared constants for the address-mode and write-protect flash link
package fwp_pkg;
    // Command opcodes
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_WRSR   = 8'h01;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_WREAR  = 8'hC5;
    localparam logic [7:0] OP_EN4B   = 8'hB7;
    localparam logic [7:0] OP_EX4B   = 8'hE9;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_PP     = 8'h02;
    localparam logic [7:0] OP_SE     = 8'h20;
    localparam logic [7:0] OP_BE     = 8'hD8;
    localparam logic [7:0] OP_CE     = 8'hC7;
    localparam logic [7:0] OP_DPD    = 8'hB9;
    localparam logic [7:0] OP_RDPD   = 8'hAB;
    localparam logic [7:0] OP_RSTEN  = 8'h66;
    localparam logic [7:0] OP_RST    = 8'h99;
    // Array geometry
    localparam int         ADDR_W      = 25;
    localparam logic [8:0] TOP_BLOCK   = 9'h1FF;
    localparam int         LOCK_BITS   = 542;
    localparam logic [9:0] MID_LOCK_OFS = 10'h01F;
    // Extended address register
    localparam logic [7:0] EAR_RESET   = 8'h00;
    localparam int         EAR_SEL_BIT = 0;
    // Status byte bit positions
    localparam int SR_BUSY = 0;
    localparam int SR_WEL  = 1;
    localparam int SR_WPS  = 2;
    localparam int SR_EAR  = 3;
    localparam int SR_ADS  = 4;
    localparam int SR_ADP  = 5;
    localparam int SR_EE   = 6;
    localparam int SR_PE   = 7;
    // Status write data byte layout
    localparam int WR_WPS    = 0;
    localparam int WR_ADP    = 1;
    localparam int WR_BP_LSB = 2;
    localparam int BP_W      = 6;
    localparam int BP_CMP    = 5;
    // Non-volatile defaults
    localparam logic ADP_DEFAULT = 1'b0;
    localparam logic WPS_DEFAULT = 1'b0;
    localparam logic [5:0] BP_DEFAULT = 6'h00;
    // Timing
    localparam int CLK_NS     = 20;
    localparam int OP_TIME_NS = 2000;
    localparam int OP_CYCLES  = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF  = 4;
endpackage : fwp_pkg

// >>> include/fwp_spi_if.sv
// Serial link between the host controller and the flash protect logic
`timescale 1ns/1ps
`default_nettype none
interface fwp_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    modport device (input sclk, input cs_n, input mosi, output miso);
    modport host   (output sclk, output cs_n, output mosi, input miso);
endinterface : fwp_spi_if
`default_nettype wire

// >>> src/fwp_flash_dev.sv
// Flash-side address mode, extended address and write protection logic
`timescale 1ns/1ps
`default_nettype none
module fwp_flash_dev #(
    parameter int OP_CYCLES = fwp_pkg::OP_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    fwp_spi_if.device                  spi,
    input  wire logic                  legacy_protect_hit,
    output logic                       current_addr_mode_bit,
    output logic                       upper_half_select,
    output logic                       write_enable_latch,
    output logic                       busy,
    output logic                       deep_power_down,
    output logic                       program_error_flag,
    output logic                       erase_error_flag,
    output logic                       protect_scheme_select,
    output logic                       power_up_addr_mode_bit,
    output logic [fwp_pkg::BP_W-1:0]   block_protect_bits,
    output logic [fwp_pkg::ADDR_W-1:0] target_addr,
    output logic                       op_start,
    output logic [7:0]                 op_code,
    output logic                       op_done
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage 1 feeds only stage 2
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2, cs_s3;
    logic mosi_s1, mosi_s2;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {cs_s1, cs_s2, cs_s3}       <= 3'h7;
            {mosi_s1, mosi_s2}          <= 2'h0;
        end else begin
            {sclk_s1, sclk_s2, sclk_s3} <= {spi.sclk, sclk_s1, sclk_s2};
            {cs_s1, cs_s2, cs_s3}       <= {spi.cs_n, cs_s1, cs_s2};
            {mosi_s1, mosi_s2}          <= {spi.mosi, mosi_s1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode
    logic [2:0] bitpos_r, byte_idx_r;
    logic [7:0] shift_r, opcode_r, data_r;
    logic [31:0] addr_r;
    logic       got_data_r;
    logic       ear_r, four_r, wel_r, busy_r, dpd_r, rst_armed_r;
    logic       adp_r, wps_r, pe_r, ee_r;
    logic [fwp_pkg::BP_W-1:0] bp_r;
    logic [fwp_pkg::LOCK_BITS-1:0] lock_r;

    wire        cs_act    = ~cs_s2;
    wire        sclk_rise = sclk_s2 & ~sclk_s3 & cs_act;
    wire        sclk_fall = ~sclk_s2 & sclk_s3 & cs_act;
    wire        cs_rise   = cs_s2 & ~cs_s3;
    wire        byte_done = sclk_rise & (bitpos_r == 3'h7);
    wire [7:0]  byte_val  = {shift_r[6:0], mosi_s2};
    wire        has_addr  = (opcode_r == fwp_pkg::OP_PP) | (opcode_r == fwp_pkg::OP_SE)
                          | (opcode_r == fwp_pkg::OP_BE) | (opcode_r == fwp_pkg::OP_UNLOCK);
    wire [2:0]  addr_len  = four_r ? 3'h4 : 3'h3;
    wire [2:0]  data_idx  = has_addr ? addr_len + 3'h1 : 3'h1;
    wire        whole     = (bitpos_r == 3'h0) & (byte_idx_r != 3'h0);
    wire        addr_ok   = byte_idx_r > addr_len;

    // Counting bits and bytes; saturate byte index for long program frames
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bitpos_r   <= 3'h0;
            byte_idx_r <= 3'h0;
            shift_r    <= 8'h00;
        end else if (!cs_act) begin
            bitpos_r   <= 3'h0;
            byte_idx_r <= 3'h0;
        end else if (sclk_rise) begin
            shift_r  <= byte_val;
            bitpos_r <= bitpos_r + 3'h1;
            if (byte_done && byte_idx_r != 3'h7)
                byte_idx_r <= byte_idx_r + 3'h1;
        end
    end

    // Opcode, address and data capture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            opcode_r   <= 8'h00;
            addr_r     <= 32'h0000_0000;
            data_r     <= 8'h00;
            got_data_r <= 1'b0;
        end else if (cs_rise) begin
            got_data_r <= 1'b0;
        end else if (byte_done) begin
            if (byte_idx_r == 3'h0) begin
                opcode_r <= byte_val;
                addr_r   <= 32'h0000_0000;
            end else if (has_addr && byte_idx_r <= addr_len) begin
                addr_r <= {addr_r[23:0], byte_val};
            end else if (byte_idx_r == data_idx && !got_data_r) begin
                data_r     <= byte_val;
                got_data_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective address and lock lookup
    wire [fwp_pkg::ADDR_W-1:0] eff_addr = four_r ? addr_r[24:0]
                                                 : {ear_r, addr_r[23:0]};
    wire [8:0]  blk       = eff_addr[24:16];
    wire [3:0]  sec       = eff_addr[15:12];
    wire        is_bottom = (blk == 9'h000);
    wire        is_top    = (blk == fwp_pkg::TOP_BLOCK);
    wire [9:0]  lock_idx  = is_bottom ? {6'h00, sec}
                          : is_top    ? {6'h01, sec}
                          : {1'b0, blk} + fwp_pkg::MID_LOCK_OFS;
    wire        bottom_any = |lock_r[15:0];
    wire        top_any    = |lock_r[31:16];
    wire        be_end     = (opcode_r == fwp_pkg::OP_BE) & (is_bottom | is_top);
    wire        lock_hit   = (opcode_r == fwp_pkg::OP_CE) ? |lock_r
                           : be_end ? (is_bottom ? bottom_any : top_any)
                           : lock_r[lock_idx];
    // Whole-chip erase touches any protected area under the legacy scheme
    wire        legacy_hit = (opcode_r == fwp_pkg::OP_CE)
                           ? (bp_r[fwp_pkg::BP_CMP] | (|bp_r[2:0])) : legacy_protect_hit;
    wire        prot_hit   = wps_r ? lock_hit : legacy_hit;
    wire        is_prog    = opcode_r == fwp_pkg::OP_PP;
    wire        is_erase   = (opcode_r == fwp_pkg::OP_SE) | (opcode_r == fwp_pkg::OP_BE)
                           | (opcode_r == fwp_pkg::OP_CE);
    wire        pe_addr_ok = (opcode_r == fwp_pkg::OP_CE) | addr_ok;
    wire        accept     = cs_rise & whole & ~busy_r;
    wire        in_dpd_ok  = (opcode_r == fwp_pkg::OP_RDPD)
                           | (opcode_r == fwp_pkg::OP_RSTEN)
                           | ((opcode_r == fwp_pkg::OP_RST) & rst_armed_r);
    wire        live       = accept & (~dpd_r | in_dpd_ok);
    wire        soft_rst   = live & (opcode_r == fwp_pkg::OP_RST) & rst_armed_r;
    wire        pe_go      = live & (is_prog | is_erase) & wel_r & pe_addr_ok;
    wire        pe_run     = pe_go & ~prot_hit;
    wire        wrsr_go    = live & (opcode_r == fwp_pkg::OP_WRSR) & wel_r & got_data_r;
    logic [15:0] op_cnt_r;
    wire        op_end     = busy_r & (op_cnt_r == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // Address mode and extension register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ear_r <= fwp_pkg::EAR_RESET[fwp_pkg::EAR_SEL_BIT];
            four_r <= fwp_pkg::ADP_DEFAULT;
        end else if (soft_rst) begin
            ear_r  <= fwp_pkg::EAR_RESET[fwp_pkg::EAR_SEL_BIT];
            four_r <= adp_r;
        end else if (live) begin
            if (opcode_r == fwp_pkg::OP_EN4B) four_r <= 1'b1;
            if (opcode_r == fwp_pkg::OP_EX4B) four_r <= 1'b0;
            if (opcode_r == fwp_pkg::OP_WREAR && got_data_r)
                ear_r <= data_r[fwp_pkg::EAR_SEL_BIT];
            else if (four_r && has_addr && addr_ok)
                ear_r <= addr_r[24];
        end
    end

    // Non-volatile status bits; a power cycle is the reset input
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            adp_r <= fwp_pkg::ADP_DEFAULT;
            wps_r <= fwp_pkg::WPS_DEFAULT;
            bp_r  <= fwp_pkg::BP_DEFAULT;
        end else if (wrsr_go) begin
            adp_r <= data_r[fwp_pkg::WR_ADP];
            wps_r <= data_r[fwp_pkg::WR_WPS];
            bp_r  <= data_r[fwp_pkg::WR_BP_LSB +: fwp_pkg::BP_W];
        end
    end

    // Write enable latch, busy timer, power-down and reset arming
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wel_r       <= 1'b0;
            busy_r      <= 1'b0;
            op_cnt_r    <= 16'h0000;
            dpd_r       <= 1'b0;
            rst_armed_r <= 1'b0;
        end else if (op_end) begin
            busy_r <= 1'b0;
            wel_r  <= 1'b0;
        end else if (busy_r) begin
            op_cnt_r <= op_cnt_r - 16'h0001;
        end else if (soft_rst) begin
            wel_r       <= 1'b0;
            dpd_r       <= 1'b0;
            rst_armed_r <= 1'b0;
        end else if (live) begin
            rst_armed_r <= opcode_r == fwp_pkg::OP_RSTEN;
            if (opcode_r == fwp_pkg::OP_WREN) wel_r <= 1'b1;
            if (opcode_r == fwp_pkg::OP_WRDI) wel_r <= 1'b0;
            if (opcode_r == fwp_pkg::OP_DPD)  dpd_r <= 1'b1;
            if (opcode_r == fwp_pkg::OP_RDPD) dpd_r <= 1'b0;
            if (pe_run || wrsr_go) begin
                busy_r   <= 1'b1;
                op_cnt_r <= 16'(OP_CYCLES - 1);
            end
        end
    end

    // Lock bits: all set at power-on and soft reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            lock_r <= '1;
        else if (soft_rst)
            lock_r <= '1;
        else if (live && opcode_r == fwp_pkg::OP_UNLOCK && addr_ok)
            lock_r[lock_idx] <= 1'b0;
    end

    // Error flags: set on protected target, cleared when that type runs again
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pe_r <= 1'b0;
            ee_r <= 1'b0;
        end else if (pe_go) begin
            if (is_prog)  pe_r <= prot_hit;
            if (is_erase) ee_r <= prot_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status readback, shifted out on falling edges
    logic [7:0] status_w;
    always_comb begin
        status_w = 8'h00;
        status_w[fwp_pkg::SR_BUSY] = busy_r;
        status_w[fwp_pkg::SR_WEL]  = wel_r;
        status_w[fwp_pkg::SR_WPS]  = wps_r;
        status_w[fwp_pkg::SR_EAR]  = ear_r;
        status_w[fwp_pkg::SR_ADS]  = four_r;
        status_w[fwp_pkg::SR_ADP]  = adp_r;
        status_w[fwp_pkg::SR_EE]   = ee_r;
        status_w[fwp_pkg::SR_PE]   = pe_r;
    end

    logic miso_r;
    wire  rd_phase = (opcode_r == fwp_pkg::OP_RDSR) & (byte_idx_r != 3'h0) & ~dpd_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            miso_r <= 1'b0;
        else if (!cs_act)
            miso_r <= 1'b0;
        else if (sclk_fall)
            miso_r <= rd_phase ? status_w[3'h7 - bitpos_r] : 1'b0;
    end
    assign spi.miso = miso_r;

    ////////////////////////////////////////////////////////////////////////////
    // User-side registered outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            target_addr <= '0;
            op_start    <= 1'b0;
            op_code     <= 8'h00;
            op_done     <= 1'b0;
        end else begin
            target_addr <= eff_addr;
            op_start    <= pe_run | wrsr_go;
            op_done     <= op_end;
            if (pe_run || wrsr_go) op_code <= opcode_r;
        end
    end

    assign current_addr_mode_bit  = four_r;
    assign upper_half_select      = ear_r;
    assign write_enable_latch     = wel_r;
    assign busy                   = busy_r;
    assign deep_power_down        = dpd_r;
    assign program_error_flag     = pe_r;
    assign erase_error_flag       = ee_r;
    assign protect_scheme_select  = wps_r;
    assign power_up_addr_mode_bit = adp_r;
    assign block_protect_bits     = bp_r;
endmodule : fwp_flash_dev
`default_nettype wire

// >>> src/fwp_flash_host.sv
// Host controller end: frames commands onto the serial link
`timescale 1ns/1ps
`default_nettype none
module fwp_flash_host #(
    parameter logic START_FOUR_BYTE = fwp_pkg::ADP_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        reset,
    fwp_spi_if.host          spi,
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_opcode,
    input  wire logic [31:0] req_addr,
    input  wire logic        req_has_addr,
    input  wire logic        req_has_data,
    input  wire logic [7:0]  req_data,
    input  wire logic        req_read,
    output logic             req_ready,
    output logic             resp_valid,
    output logic [7:0]       resp_data,
    output logic             four_byte_mode
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_GAP  = 2'b11
    } fwp_hst_t;

    fwp_hst_t    st_r;
    logic [47:0] tx_r, main_r;
    logic [5:0]  bits_r, main_bits_r;
    logic        pend_r, rd_r, miso_s1, miso_s2;
    logic [7:0]  rx_r;
    logic [7:0]  div_r;
    logic        sclk_r, cs_n_r;

    ////////////////////////////////////////////////////////////////////////////
    // Frame assembly; write-type commands get a write enable frame first
    wire needs_wel = (req_opcode == fwp_pkg::OP_PP) | (req_opcode == fwp_pkg::OP_SE)
                   | (req_opcode == fwp_pkg::OP_BE) | (req_opcode == fwp_pkg::OP_CE)
                   | (req_opcode == fwp_pkg::OP_WRSR);
    wire [2:0]  alen   = req_has_addr ? (four_byte_mode ? 3'h4 : 3'h3) : 3'h0;
    wire [2:0]  nbytes = 3'h1 + alen + {2'h0, req_has_data | req_read};
    wire [31:0] abytes = four_byte_mode ? req_addr : {req_addr[23:0], 8'h00};
    wire [47:0] frame  = req_has_addr
                       ? {req_opcode, abytes, 8'h00} | (48'(req_data) << (6'd32 - 6'(alen) * 6'd8))
                       : {req_opcode, req_data, 32'h0000_0000};
    wire [5:0]  fbits  = {nbytes, 3'h0};
    wire        tick   = div_r == 8'(fwp_pkg::SCLK_HALF - 1);
    wire        last   = bits_r == 6'h01;

    // Link miso is from another domain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) {miso_s1, miso_s2} <= 2'h0;
        else       {miso_s1, miso_s2} <= {spi.miso, miso_s1};
    end

    // Half-period divider for the serial clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset)                   div_r <= 8'h00;
        else if (st_r == ST_IDLE || tick) div_r <= 8'h00;
        else                         div_r <= div_r + 8'h01;
    end

    // Mode tracking mirrors what the flash sees
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            four_byte_mode <= START_FOUR_BYTE;
        else if (st_r == ST_IDLE && req_valid && !pend_r) begin
            if (req_opcode == fwp_pkg::OP_EN4B) four_byte_mode <= 1'b1;
            if (req_opcode == fwp_pkg::OP_EX4B) four_byte_mode <= 1'b0;
            if (req_opcode == fwp_pkg::OP_RST)  four_byte_mode <= START_FOUR_BYTE;
        end
    end

    // Frame sequencer, mode 0: data set while low, sampled on rise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= ST_IDLE; tx_r <= '0; main_r <= '0; bits_r <= 6'h00;
            main_bits_r <= 6'h00; pend_r <= 1'b0; rd_r <= 1'b0; rx_r <= 8'h00;
            sclk_r <= 1'b0; cs_n_r <= 1'b1; resp_valid <= 1'b0; resp_data <= 8'h00;
        end else begin
            resp_valid <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (pend_r) begin
                        tx_r <= main_r; bits_r <= main_bits_r; pend_r <= 1'b0;
                        cs_n_r <= 1'b0; st_r <= ST_LOW;
                    end else if (req_valid) begin
                        rd_r <= req_read;
                        cs_n_r <= 1'b0; st_r <= ST_LOW;
                        if (needs_wel) begin
                            tx_r <= {fwp_pkg::OP_WREN, 40'h0}; bits_r <= 6'h08;
                            main_r <= frame; main_bits_r <= fbits; pend_r <= 1'b1;
                        end else begin
                            tx_r <= frame; bits_r <= fbits;
                        end
                    end
                end
                ST_LOW: if (tick) begin
                    sclk_r <= 1'b1; st_r <= ST_HIGH;
                end
                // Read bit taken late in the high phase; the reply needs ~6 clk round trip
                ST_HIGH: if (tick) begin
                    sclk_r <= 1'b0; tx_r <= {tx_r[46:0], 1'b0};
                    rx_r <= {rx_r[6:0], miso_s2};
                    bits_r <= bits_r - 6'h01;
                    st_r <= last ? ST_GAP : ST_LOW;
                end
                ST_GAP: if (tick) begin
                    // Frame ends only on a whole byte, then a deselect gap
                    if (!cs_n_r) begin
                        cs_n_r <= 1'b1;
                        if (!pend_r) begin
                            resp_valid <= rd_r; resp_data <= rx_r;
                        end
                    end else begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) req_ready <= 1'b0;
        else       req_ready <= (st_r == ST_IDLE) & ~pend_r & ~req_valid;
    end

    assign spi.sclk = sclk_r;
    assign spi.cs_n = cs_n_r;
    assign spi.mosi = tx_r[47];
endmodule : fwp_flash_host
`default_nettype wire

// >>> verification/fwp_asserts.sv
// Wire checks on the serial link between host and flash ends
`timescale 1ns/1ps
`default_nettype none
module fwp_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic       sk_r;
    logic       cs_r;
    logic [7:0] sh_r;
    logic [7:0] op_r;
    logic [7:0] pv_r;
    logic [7:0] n_r;
    wire        rise = !cs_n && sclk && !sk_r;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    // Bit count and opcode per frame, sampled like the device does
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {sk_r, cs_r, sh_r, op_r, pv_r, n_r} <= {2'h1, 32'h0};
        end else begin
            sk_r <= sclk;
            cs_r <= cs_n;
            n_r  <= (cs_r && !cs_n) ? 8'h00 : n_r + 8'(rise);
            sh_r <= rise ? {sh_r[6:0], mosi} : sh_r;
            op_r <= (n_r == 8'h08) ? sh_r : op_r;
            pv_r <= (cs_n && !cs_r) ? op_r : pv_r;
        end
    end
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("clock moved outside a frame");
    a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("select gap too short");
    a_sclk_high_span: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("clock high phase wrong");
    a_sclk_low_span: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("clock low phase short");
    a_mosi_hold: assert property ($rose(sclk) |=> $stable(mosi) [*3])
        else $error("data moved while clock high");
    a_byte_bound: assert property ($rose(cs_n) |-> n_r != 8'h00 && n_r[2:0] == 3'h0)
        else $error("frame not whole bytes");
    a_wren_first: assert property ($rose(cs_n) && op_r inside {8'h02, 8'h20, 8'hD8, 8'hC7,
        8'h01} |-> pv_r == fwp_pkg::OP_WREN)
        else $error("write without enable frame");
    a_wrear_len: assert property ($rose(cs_n) && op_r == fwp_pkg::OP_WREAR |-> n_r == 8'h10)
        else $error("extension write length");
endmodule : fwp_asserts
`default_nettype wire

// >>> verification/tb.sv
// Bench joining host and flash ends, checked against a small model
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0, reset = 1'h1, req_valid = 1'h0, req_has_addr = 1'h0;
    logic req_has_data = 1'h0, req_read = 1'h0, legacy_protect_hit = 1'h0;
    logic [7:0] req_opcode = 8'h00, req_data = 8'h00, rsp;
    logic [31:0] req_addr = 32'h0, a;
    int errors = 0, comparisons = 0, seed = 91;
    int m_ads = 0, m_sel = 0, m_wel = 0, m_wps = 0, m_ee = 0;
    int n_start = 0, n_done = 0;
    wire logic req_ready, resp_valid, four_byte_mode, current_addr_mode_bit, upper_half_select;
    wire logic write_enable_latch, busy, deep_power_down, program_error_flag, erase_error_flag;
    wire logic protect_scheme_select, power_up_addr_mode_bit, op_start, op_done;
    wire logic [7:0] resp_data, op_code;
    wire logic [5:0] block_protect_bits;
    wire logic [24:0] target_addr;
    fwp_spi_if spi ();
    fwp_flash_host i_fwp_flash_host (.*);
    fwp_flash_dev #(.OP_CYCLES(5)) i_fwp_flash_dev (.*);
    fwp_asserts i_fwp_asserts (.clk(clk), .reset(reset), .sclk(spi.sclk), .cs_n(spi.cs_n),
        .mosi(spi.mosi), .miso(spi.miso));
    ////////////////////////////////////////////////////////////
    // Free-running 50 MHz clock
    always #10 clk = ~clk;
    // Count start and done pulses of the operation timer
    always @(posedge clk) begin
        n_start += op_start;
        n_done += op_done;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask : check
    // One host request, then wait for idle and for the flash to settle
    task automatic req(input logic [7:0] op, input logic [31:0] ad, input logic [7:0] d,
        input logic ha, input logic hd, input logic rd);
        int n;
        @(posedge clk);
        {req_valid, req_opcode, req_addr, req_data, req_has_addr, req_has_data, req_read}
            <= {1'h1, op, ad, d, ha, hd, rd};
        @(posedge clk);
        req_valid <= 1'h0;
        rsp = 8'hXX;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (resp_valid === 1'h1) rsp = resp_data;
        end while (req_ready !== 1'h1 && n < 3000);
        check(req_ready, 1, "request hang");
        repeat (8) @(posedge clk);
        for (n = 0; busy !== 1'h0 && n < 100; n++) @(posedge clk);
        check(busy, 0, "op hang");
    endtask : req
    task automatic cmd(input logic [7:0] op);
        req(op, 32'h0, 8'h00, 1'h0, 1'h0, 1'h0);
    endtask : cmd
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        req(op, 32'h0, d, 1'h0, 1'h1, 1'h0);
    endtask : wr
    // Status byte and pins against the model
    task automatic chk_all();
        req(fwp_pkg::OP_RDSR, 32'h0, 8'h00, 1'h0, 1'h0, 1'h1);
        check(rsp, {1'h0, m_ee[0], 1'h0, m_ads[0], m_sel[0], m_wps[0], m_wel[0], 1'h0},
            "status");
        check(current_addr_mode_bit, m_ads, "mode");
        check(upper_half_select, m_sel, "select");
        check(four_byte_mode, m_ads, "host mode");
    endtask : chk_all
    // Refused erase keeps the latch, a done one clears it
    task automatic erase(input logic [31:0] ad, input int ee);
        req(fwp_pkg::OP_SE, ad, 8'h00, 1'h1, 1'h0, 1'h0);
        m_ee = ee;
        m_wel = ee;
        chk_all();
    endtask : erase
    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Watchdog well past the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        repeat (5) @(posedge clk);
        chk_all();
        for (int i = 0; i < 4; i++) begin
            a = $random(seed);
            wr(fwp_pkg::OP_WREAR, a[7:0]);
            m_sel = a[0];
            chk_all();
        end
        cmd(fwp_pkg::OP_WREN);
        m_wel = 1;
        chk_all();
        cmd(fwp_pkg::OP_EN4B);
        a = $random(seed);
        req(fwp_pkg::OP_PP, a, 8'hA5, 1'h1, 1'h1, 1'h0);
        {m_ads, m_sel, m_wel} = {32'h1, 31'h0, a[24], 32'h0};
        check(target_addr, a[24:0], "wide target");
        check(op_code, fwp_pkg::OP_PP, "op code");
        chk_all();
        cmd(fwp_pkg::OP_EX4B);
        m_ads = 0;
        wr(fwp_pkg::OP_WREAR, 8'h01);
        req(fwp_pkg::OP_PP, 32'h00123456, 8'h5A, 1'h1, 1'h1, 1'h0);
        check(target_addr, 32'h01123456, "narrow target");
        m_sel = 1;
        wr(fwp_pkg::OP_WRSR, 8'h01);
        m_wps = 1;
        chk_all();
        check(protect_scheme_select, 1, "scheme");
        check(power_up_addr_mode_bit, 0, "power-up bit");
        erase(32'h00100000, 1);
        req(fwp_pkg::OP_UNLOCK, 32'h00100000, 8'h00, 1'h1, 1'h0, 1'h0);
        erase(32'h00100000, 0);
        req(fwp_pkg::OP_UNLOCK, 32'h00FF0000, 8'h00, 1'h1, 1'h0, 1'h0);
        erase(32'h00FF1000, 1);
        wr(fwp_pkg::OP_WRSR, 8'h00);
        m_wps = 0;
        erase(32'h00FF1000, 0);
        legacy_protect_hit <= 1'h1;
        erase(32'h00FF1000, 1);
        cmd(fwp_pkg::OP_DPD);
        wr(fwp_pkg::OP_WREAR, 8'h00);
        check(deep_power_down, 1, "asleep");
        check(upper_half_select, 1, "asleep select");
        cmd(fwp_pkg::OP_RDPD);
        cmd(fwp_pkg::OP_EN4B);
        check(current_addr_mode_bit, 1, "awake");
        cmd(fwp_pkg::OP_RSTEN);
        cmd(fwp_pkg::OP_RST);
        check(current_addr_mode_bit, 0, "soft reset mode");
        check(upper_half_select, 0, "soft reset select");
        check(write_enable_latch, 0, "soft reset latch");
        cmd(fwp_pkg::OP_DPD);
        cmd(fwp_pkg::OP_RSTEN);
        cmd(fwp_pkg::OP_RST);
        check(deep_power_down, 0, "reset wakes");
        check(n_start, 6, "ops started");
        check(n_done, 6, "ops done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
